/* File: rtl/reset_source_sequencer.sv */
// Overview of operation
// - Power-on presets ports high, execution at zero
// - Hold core for post-reset delay afterwards
// - Option chooses reset pin or port bit
// - Low reset pin keeps core in reset
// - Pin reset zeroes program counter, then runs
// - Undervoltage must persist minimum time to reset
// - Running watchdog time-out acts as pin reset
// - Sleeping watchdog time-out clears only PC, SP
// - Wake from watchdog waits oscillator start-up time
// - Cause flags updated per reset type
// - Reset disables all interrupt sources
// - Reset clears watchdog, counting starts after
// - Reset switches timer counters off
// - Ports inputs, analog pins to converter
// - Stack pointer set to top after reset
// - Low-voltage reset is full pin-like reset
// - Watchdog cleared by pin, clear, halt
`timescale 1ns/10ps
`default_nettype none
`include "rss_defines.svh"

module reset_source_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned POST_RESET_CYCLES =
        `RSS_POST_RESET_DELAY_MS * 1000 * `RSS_CLK_MHZ,
    parameter int unsigned UV_MIN_CYCLES =
        (`RSS_UV_MIN_NS * `RSS_CLK_MHZ + 999) / 1000
) (
    // Clock, reset, enable
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output var  logic [7:0] regRdData,
    // Pins and supply monitor
    input  wire logic       external_reset_pin_n,
    input  wire logic       underVoltage,
    // Core and watchdog side
    input  wire logic       wdtTimeout,
    input  wire logic       sleepMode,
    input  wire logic       wdtClearInstr,
    input  wire logic       haltInstr,
    // Reset controls to the core
    output var  logic       coreReset,
    output var  logic       startUpWait,
    output var  logic       pcClear,
    output var  logic       spClear,
    output var  logic       periphInit,
    output var  logic       wdtClear,
    // Cause flags and shared pin
    output var  logic       timeout_cause_flag,
    output var  logic       power_down_flag,
    output var  logic       shared_port_bit
);
    localparam int CW = $clog2(POST_RESET_CYCLES + `RSS_START_XTAL_CLKS + 1);

    rss_uv_if uvBus ();

    // Registers
    rss_state_e  state_ff;
    rss_state_e  nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [7:0]  ctrl_ff;
    logic        pinMeta_ff;
    logic        pinSync_ff;
    logic        uvMeta_ff;
    logic        uvSync_ff;
    logic        to_ff;
    logic        pwrDown_ff;
    logic        coreReset_ff;
    logic        startUp_ff;
    logic        pcClear_ff;
    logic        spClear_ff;
    logic        wdtClear_ff;
    logic        portBit_ff;
    logic [7:0]  rdData_ff;

    // Decode
    logic        pinIsReset;
    logic        uvRstEn;
    rss_osc_e    oscSel;
    logic        extActive;
    logic        anyActive;
    logic        wdtRunEvt;
    logic        wdtSleepEvt;
    logic        nxtFull;
    logic        nxtWake;
    logic [CW-1:0] startLimit;
    logic        delayDone;
    logic        startDone;
    logic        wrCtrl;
    logic        wrStat;
    logic        toClr;
    logic        pwrDownClr;
    logic [7:0]  statView;
    logic [7:0]  rdMux;

    assign pinIsReset = ctrl_ff[`RSS_CTRL_PINRST];
    assign uvRstEn    = ctrl_ff[`RSS_CTRL_UVEN];
    assign oscSel     = rss_osc_e'(ctrl_ff[`RSS_CTRL_OSC_HI:`RSS_CTRL_OSC_LO]);

    // Low-voltage path shares the pin path's full reset
    assign extActive  = pinIsReset && !pinSync_ff;
    assign anyActive  = extActive || uvBus.qualified;

    assign uvBus.clkEn  = clkEn;
    assign uvBus.enable = uvRstEn;
    assign uvBus.rawLow = uvSync_ff;

    rss_uv_filter #(
        .MIN_CYCLES (UV_MIN_CYCLES)
    ) uFilter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .uv       (uvBus.filt)
    );

    // Watchdog only counts as an event once the core is running
    assign wdtRunEvt   = (state_ff == RSS_ST_RUN) && !anyActive
                         && wdtTimeout && !sleepMode;
    assign wdtSleepEvt = (state_ff == RSS_ST_RUN) && !anyActive
                         && wdtTimeout && sleepMode;

    always_comb begin
        unique case (oscSel)
            RSS_OSC_RC:   startLimit = CW'(`RSS_START_RC_CLKS);
            RSS_OSC_XTAL: startLimit = CW'(`RSS_START_XTAL_CLKS);
            RSS_OSC_SLOW: startLimit = CW'(`RSS_START_SLOW_CLKS);
            default:      startLimit = CW'(`RSS_START_XTAL_CLKS);
        endcase
    end

    assign delayDone = (cnt_ff == CW'(POST_RESET_CYCLES - 1));
    assign startDone = (cnt_ff == startLimit - CW'(1));

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            RSS_ST_RESET: begin
                nxt_cnt = '0;
                if (!anyActive) begin
                    nxt_state = RSS_ST_DELAY;
                end
            end
            RSS_ST_DELAY: begin
                if (anyActive) begin
                    nxt_state = RSS_ST_RESET;
                    nxt_cnt   = '0;
                end else if (delayDone) begin
                    nxt_state = RSS_ST_RUN;
                    nxt_cnt   = '0;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
            RSS_ST_RUN: begin
                nxt_cnt = '0;
                if (anyActive || wdtRunEvt) begin
                    nxt_state = RSS_ST_RESET;
                end else if (wdtSleepEvt) begin
                    nxt_state = RSS_ST_START;
                end
            end
            RSS_ST_START: begin
                if (anyActive) begin
                    nxt_state = RSS_ST_RESET;
                    nxt_cnt   = '0;
                end else if (startDone) begin
                    nxt_state = RSS_ST_RUN;
                    nxt_cnt   = '0;
                end else begin
                    nxt_cnt = cnt_ff + CW'(1);
                end
            end
        endcase
    end

    assign nxtFull = (nxt_state == RSS_ST_RESET)
                     || (nxt_state == RSS_ST_DELAY);
    assign nxtWake = wdtSleepEvt;

    // Register port; a flag set in the same cycle beats its clear
    assign wrCtrl = regWr && (regAddr == `RSS_ADDR_CTRL);
    assign wrStat = regWr && (regAddr == `RSS_ADDR_STAT);
    assign toClr  = wrStat && regWrData[`RSS_STAT_TO];
    assign pwrDownClr = wrStat && regWrData[`RSS_STAT_PWRDN];

    always_comb begin
        statView = 8'h00;
        statView[`RSS_STAT_TO]   = to_ff;
        statView[`RSS_STAT_PWRDN] = pwrDown_ff;
        statView[`RSS_STAT_BUSY] = coreReset_ff || startUp_ff;
        statView[`RSS_STAT_UV]   = uvBus.qualified;
    end

    assign rdMux = (regAddr == `RSS_ADDR_CTRL) ? ctrl_ff :
                   (regAddr == `RSS_ADDR_STAT) ? statView : 8'h00;

    // Two-stage synchronisers for the pin and the monitor
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pinMeta_ff <= 1'b1;
            pinSync_ff <= 1'b1;
            uvMeta_ff  <= 1'b0;
            uvSync_ff  <= 1'b0;
            portBit_ff <= 1'b1;
        end else if (clkEn) begin
            pinMeta_ff <= external_reset_pin_n;
            pinSync_ff <= pinMeta_ff;
            uvMeta_ff  <= underVoltage;
            uvSync_ff  <= uvMeta_ff;
            portBit_ff <= pinSync_ff;
        end
    end

    // Power-on starts held in reset, flags cleared
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff <= RSS_ST_RESET;
            cnt_ff   <= '0;
            ctrl_ff  <= `RSS_CTRL_RST;
            to_ff    <= 1'b0;
            pwrDown_ff <= 1'b0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (wrCtrl) begin
                ctrl_ff <= regWrData;
            end
            if (wdtRunEvt || wdtSleepEvt) begin
                to_ff <= 1'b1;
            end else if (toClr) begin
                to_ff <= 1'b0;
            end
            if (wdtSleepEvt) begin
                pwrDown_ff <= 1'b1;
            end else if (pwrDownClr) begin
                pwrDown_ff <= 1'b0;
            end
        end
    end

    // Full reset holds PC at zero and presets peripherals
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            coreReset_ff <= 1'b1;
            startUp_ff   <= 1'b0;
            pcClear_ff   <= 1'b1;
            spClear_ff   <= 1'b0;
            wdtClear_ff  <= 1'b1;
            rdData_ff    <= 8'h00;
        end else if (clkEn) begin
            coreReset_ff <= nxtFull;
            startUp_ff   <= (nxt_state == RSS_ST_START);
            pcClear_ff   <= nxtFull || nxtWake;
            spClear_ff   <= nxtWake;
            wdtClear_ff  <= nxtFull || extActive || wdtClearInstr
                            || haltInstr;
            rdData_ff    <= regRd ? rdMux : 8'h00;
        end
    end

    assign regRdData          = rdData_ff;
    assign coreReset          = coreReset_ff;
    assign startUpWait        = startUp_ff;
    assign pcClear            = pcClear_ff;
    assign spClear            = spClear_ff;
    // Ports to inputs, interrupts off, timers off, SP to top
    assign periphInit         = coreReset_ff;
    assign wdtClear           = wdtClear_ff;
    assign timeout_cause_flag = to_ff;
    assign power_down_flag    = pwrDown_ff;
    assign shared_port_bit    = portBit_ff;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    property p_por_flags;
        $rose(reset_n) |-> !timeout_cause_flag && !power_down_flag
                           && coreReset && pcClear;
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("Power-on did not clear flags or hold core");

    property p_pin_holds;
        (clkEn && extActive) |=> coreReset && pcClear && periphInit;
    endproperty
    a_pin_holds: assert property (p_pin_holds)
        else $error("Core left reset while pin low");

    property p_delay_holds;
        (clkEn && state_ff == RSS_ST_DELAY && !anyActive && !delayDone)
            |=> coreReset && state_ff == RSS_ST_DELAY;
    endproperty
    a_delay_holds: assert property (p_delay_holds)
        else $error("Post-reset delay ended early");

    property p_wdt_run;
        (clkEn && wdtRunEvt) |=> timeout_cause_flag && coreReset
                                 ##1 (!clkEn || coreReset);
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("Running time-out not handled as pin reset");

    property p_wdt_sleep;
        (clkEn && wdtSleepEvt) |=> spClear && pcClear && !coreReset
                                   && timeout_cause_flag && power_down_flag;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep)
        else $error("Sleep time-out handled wrongly");

    property p_start_wait;
        (clkEn && state_ff == RSS_ST_START && !anyActive && !startDone)
            |=> startUpWait;
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("Start-up wait cut short");

    property p_shared_bit;
        (clkEn && !pinIsReset) |-> !extActive
            ##1 (!$past(clkEn) || shared_port_bit == $past(pinSync_ff));
    endproperty
    a_shared_bit: assert property (p_shared_bit)
        else $error("Port bit mode wrong");

    property p_wdt_clear;
        (clkEn && (wdtClearInstr || haltInstr)) |=> wdtClear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("Watchdog not cleared");

    property p_restart;
        (clkEn && state_ff == RSS_ST_DELAY && anyActive)
            |=> state_ff == RSS_ST_RESET && coreReset;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Delay not restarted by new source");

    property p_uv_full;
        (clkEn && uvBus.qualified) |=> coreReset && periphInit;
    endproperty
    a_uv_full: assert property (p_uv_full)
        else $error("Qualified undervoltage did not reset");
endmodule

`default_nettype wire

/* File: rtl/rss_defines.svh */
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Core clock rate
`define RSS_CLK_MHZ             100
// Post-reset delay, milliseconds
`define RSS_POST_RESET_DELAY_MS 100
// Undervoltage qualifying time, nanoseconds (least time)
`define RSS_UV_MIN_NS           1000
// Start-up wait in oscillator clocks, per oscillator class
`define RSS_START_RC_CLKS       16
`define RSS_START_XTAL_CLKS     1024
`define RSS_START_SLOW_CLKS     2

// Register offsets and control reset value
`define RSS_ADDR_CTRL           8'h00
`define RSS_ADDR_STAT           8'h04
`define RSS_CTRL_RST            8'h03

// Control fields
`define RSS_CTRL_PINRST         0
`define RSS_CTRL_UVEN           1
`define RSS_CTRL_OSC_LO         2
`define RSS_CTRL_OSC_HI         3

// Status fields
`define RSS_STAT_TO             0
`define RSS_STAT_PWRDN          1
`define RSS_STAT_BUSY           2
`define RSS_STAT_UV             3

`endif

/* File: rtl/rss_pkg.sv */
package rss_pkg;

    typedef enum {
        RSS_ST_RESET,
        RSS_ST_DELAY,
        RSS_ST_RUN,
        RSS_ST_START
    } rss_state_e;

    typedef enum logic [1:0] {
        RSS_OSC_RC   = 2'h0,
        RSS_OSC_XTAL = 2'h1,
        RSS_OSC_SLOW = 2'h2
    } rss_osc_e;

endpackage

/* File: rtl/rss_uv_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface rss_uv_if;
    logic clkEn;
    logic enable;
    logic rawLow;
    logic qualified;

    modport filt (
        input  clkEn,
        input  enable,
        input  rawLow,
        output qualified
    );

    modport user (
        output clkEn,
        output enable,
        output rawLow,
        input  qualified
    );
endinterface

`default_nettype wire

/* File: rtl/rss_uv_filter.sv */
`timescale 1ns/10ps
`default_nettype none

module rss_uv_filter
    import rss_pkg::*;
#(
    parameter int unsigned MIN_CYCLES = 100
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Monitor side
    rss_uv_if.filt    uv
);
    localparam int CW = $clog2(MIN_CYCLES + 1);

    logic [CW-1:0] runCnt_ff;
    logic          qual_ff;
    logic          hit;

    assign hit = (runCnt_ff == CW'(MIN_CYCLES - 1));
    assign uv.qualified = qual_ff;

    // Any gap in the low indication restarts the qualification
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            runCnt_ff <= '0;
            qual_ff   <= 1'b0;
        end else if (uv.clkEn) begin
            if (!uv.enable || !uv.rawLow) begin
                runCnt_ff <= '0;
                qual_ff   <= 1'b0;
            end else if (hit) begin
                qual_ff   <= 1'b1;
            end else begin
                runCnt_ff <= runCnt_ff + CW'(1);
            end
        end
    end

    property p_uv_short_ignored;
        @(posedge core_clk) disable iff (!reset_n)
        (uv.clkEn && !uv.rawLow) |=> !uv.qualified;
    endproperty
    a_uv_short_ignored: assert property (p_uv_short_ignored)
        else $error("Undervoltage qualified without a low indication");

    property p_uv_needs_run;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(uv.qualified) |-> $past(uv.rawLow) && $past(uv.enable);
    endproperty
    a_uv_needs_run: assert property (p_uv_needs_run)
        else $error("Undervoltage qualified while disabled");
endmodule

`default_nettype wire

/* File: tb/rss_supply_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Far side: RC network on the reset pin and the supply monitor
module rss_supply_model #(
    parameter int RC_HOLD = 3
) (
    // Clock
    input  wire logic core_clk,
    // Bench commands
    input  wire logic pressPin,
    input  wire logic supplyLow,
    // Pins
    output var  logic external_reset_pin_n,
    output var  logic underVoltage
);
    int holdCnt = 0;

    // Capacitor keeps the pin low a while after release; pull-up then wins
    always @(posedge core_clk) begin
        if (pressPin) begin
            holdCnt <= RC_HOLD;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
    end

    assign external_reset_pin_n = !(pressPin || holdCnt > 0);
    assign underVoltage = supplyLow;
endmodule

`default_nettype wire

/* File: tb/reset_source_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rss_defines.svh"

module reset_source_sequencer_tb_top
    import rss_pkg::*;
;
    // Short counts keep the run brief
    localparam int PRC = 20;
    localparam int UVC = 4;
    localparam int RCH = 3;

    logic       core_clk;
    logic       reset_n;
    logic       clkEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdData;
    logic       external_reset_pin_n;
    logic       underVoltage;
    logic       wdtTimeout;
    logic       sleepMode;
    logic       wdtClearInstr;
    logic       haltInstr;
    logic       coreReset;
    logic       startUpWait;
    logic       pcClear;
    logic       spClear;
    logic       periphInit;
    logic       wdtClear;
    logic       timeout_cause_flag;
    logic       power_down_flag;
    logic       shared_port_bit;
    logic       pressPin;
    logic       supplyLow;
    logic [7:0] rd;
    int         failures = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         n;
    int         waitTab [4] = '{`RSS_START_RC_CLKS, `RSS_START_XTAL_CLKS,
                                `RSS_START_SLOW_CLKS, `RSS_START_XTAL_CLKS};

    reset_source_sequencer #(
        .POST_RESET_CYCLES(PRC),
        .UV_MIN_CYCLES    (UVC)
    ) uut (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .clkEn               (clkEn),
        .regAddr             (regAddr),
        .regWrData           (regWrData),
        .regWr               (regWr),
        .regRd               (regRd),
        .regRdData           (regRdData),
        .external_reset_pin_n(external_reset_pin_n),
        .underVoltage        (underVoltage),
        .wdtTimeout          (wdtTimeout),
        .sleepMode           (sleepMode),
        .wdtClearInstr       (wdtClearInstr),
        .haltInstr           (haltInstr),
        .coreReset           (coreReset),
        .startUpWait         (startUpWait),
        .pcClear             (pcClear),
        .spClear             (spClear),
        .periphInit          (periphInit),
        .wdtClear            (wdtClear),
        .timeout_cause_flag  (timeout_cause_flag),
        .power_down_flag     (power_down_flag),
        .shared_port_bit     (shared_port_bit)
    );

    rss_supply_model #(
        .RC_HOLD(RCH)
    ) farSide (
        .core_clk            (core_clk),
        .pressPin            (pressPin),
        .supplyLow           (supplyLow),
        .external_reset_pin_n(external_reset_pin_n),
        .underVoltage        (underVoltage)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the expected length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Cycles until the core leaves reset, bounded
    task automatic wait_run(output int k);
        k = 0;
        while (coreReset !== 1'b0 && k < 200) begin
            tick(1);
            k++;
        end
    endtask

    task automatic wdt_fire(input logic slp);
        @(posedge core_clk);
        wdtTimeout <= 1'b1;
        sleepMode  <= slp;
        @(posedge core_clk);
        wdtTimeout <= 1'b0;
        sleepMode  <= 1'b0;
        #1;
    endtask

    task automatic supply_dip(input int k);
        @(posedge core_clk);
        supplyLow <= 1'b1;
        repeat (k) @(posedge core_clk);
        supplyLow <= 1'b0;
        #1;
    endtask

    initial begin
        reset_n = 1'b0;
        clkEn = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        wdtTimeout = 1'b0;
        sleepMode = 1'b0;
        wdtClearInstr = 1'b0;
        haltInstr = 1'b0;
        pressPin = 1'b0;
        supplyLow = 1'b0;
        tick(2);
        check(16'({coreReset, pcClear, wdtClear}), 16'h7);
        check(16'(periphInit), 16'h1);
        check(16'({startUpWait, spClear, timeout_cause_flag,
                   power_down_flag}), 16'h0);
        @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        wait_run(n);
        check(16'(n >= PRC && n <= PRC + 3), 16'h1);
        check(16'({pcClear, periphInit, shared_port_bit}), 16'h1);
        reg_rd(`RSS_ADDR_CTRL, rd);
        check(16'(rd), 16'h03);
        tick(1);
        check(16'(regRdData), 16'h00);
        reg_wr(8'h10, 8'hFF);
        reg_rd(8'h10, rd);
        check(16'(rd), 16'h00);
        // Strobes are ignored while the clock enable is low
        @(posedge core_clk);
        clkEn <= 1'b0;
        reg_wr(`RSS_ADDR_CTRL, 8'h00);
        @(posedge core_clk);
        clkEn <= 1'b1;
        reg_rd(`RSS_ADDR_CTRL, rd);
        check(16'(rd), 16'h03);
        // Watchdog while running
        wdt_fire(1'b0);
        check(16'({coreReset, timeout_cause_flag, power_down_flag}),
              16'h6);
        wait_run(n);
        check(16'(n >= PRC && n <= PRC + 3), 16'h1);
        // Pin reset leaves the flags alone
        @(posedge core_clk);
        pressPin <= 1'b1;
        tick(12);
        check(16'({coreReset, pcClear, wdtClear, periphInit}),
              16'hF);
        check(16'({timeout_cause_flag, power_down_flag}), 16'h2);
        reg_rd(`RSS_ADDR_STAT, rd);
        check(16'(rd), 16'h05);
        @(posedge core_clk);
        pressPin <= 1'b0;
        #1;
        wait_run(n);
        check(16'(n >= PRC + RCH && n <= PRC + RCH + 8), 16'h1);
        // New source in mid-delay restarts it
        @(posedge core_clk);
        pressPin <= 1'b1;
        @(posedge core_clk);
        pressPin <= 1'b0;
        tick(RCH + 12);
        supply_dip(10);
        check(16'(coreReset), 16'h1);
        reg_rd(`RSS_ADDR_STAT, rd);
        check(16'(rd), 16'h0D);
        wait_run(n);
        check(16'(n >= PRC && n <= PRC + 8), 16'h1);
        // Short dip, then a long one with the option off
        supply_dip(UVC - 1);
        tick(12);
        check(16'(coreReset), 16'h0);
        reg_wr(`RSS_ADDR_CTRL, 8'h01);
        supply_dip(12);
        tick(4);
        check(16'(coreReset), 16'h0);
        // Pin as port bit
        reg_wr(`RSS_ADDR_CTRL, 8'h02);
        @(posedge core_clk);
        pressPin <= 1'b1;
        tick(6);
        check(16'({coreReset, shared_port_bit}), 16'h0);
        @(posedge core_clk);
        pressPin <= 1'b0;
        tick(RCH + 5);
        check(16'({coreReset, shared_port_bit}), 16'h1);
        // Software clears the flags
        reg_wr(`RSS_ADDR_STAT, 8'h03);
        reg_rd(`RSS_ADDR_STAT, rd);
        check(16'(rd), 16'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            {haltInstr, wdtClearInstr} <= 2'(1 << i);
            @(posedge core_clk);
            {haltInstr, wdtClearInstr} <= 2'b00;
            #1;
            check(16'(wdtClear), 16'h1);
            tick(2);
            check(16'(wdtClear), 16'h0);
        end
        // Watchdog wake from sleep, every oscillator class
        for (int i = 0; i < 4; i++) begin
            reg_wr(`RSS_ADDR_CTRL, 8'(i << 2) | 8'h03);
            wdt_fire(1'b1);
            check(16'({pcClear, spClear, startUpWait, coreReset}),
                  16'hE);
            check(16'({timeout_cause_flag, power_down_flag}),
                  16'h3);
            n = 0;
            while (startUpWait === 1'b1 && n < 2000) begin
                tick(1);
                n++;
            end
            check(16'(n), 16'(waitTab[i]));
            check(16'({pcClear, spClear, coreReset}), 16'h0);
            reg_wr(`RSS_ADDR_STAT, 8'h03);
        end
        // Power-on again during the wake start-up wait clears both flags
        wdt_fire(1'b1);
        @(posedge core_clk);
        reset_n <= 1'b0;
        tick(2);
        check(16'({timeout_cause_flag, power_down_flag, coreReset}),
              16'h1);
        @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        wait_run(n);
        check(16'(n >= PRC && n <= PRC + 3), 16'h1);
        close_out();
    end
endmodule

`default_nettype wire
